// file: hw/ssc_pkg.sv
// package: constants for the serial switch command parser
package ssc_pkg;
    localparam int          CLK_HZ         = 10_000_000;
    localparam logic [7:0]  CMD_SEL_A      = 8'h41;
    localparam logic [7:0]  CMD_SEL_B      = 8'h42;
    localparam logic [7:0]  CMD_SEL_C      = 8'h43;
    localparam logic [7:0]  CMD_SEL_D      = 8'h44;
    localparam logic [7:0]  CMD_OFF        = 8'h04;
    localparam logic [7:0]  CMD_SEND_ONLY  = 8'h53;
    localparam logic [7:0]  CMD_CLEAR      = 8'h58;
    localparam logic [7:0]  CMD_IGNORE     = 8'h54;
    localparam logic [7:0]  DIGIT_ZERO     = 8'h30;
    localparam logic [7:0]  DIGIT_NINE     = 8'h39;
    localparam int          NUM_PORTS      = 4;
    localparam logic [3:0]  PORT_MASK_RST  = 4'h0;
    localparam logic [1:0]  RX_PORT_RST    = 2'h0;
    // ignore durations in milliseconds
    localparam int          IGN_MS_1       = 10;
    localparam int          IGN_MS_2       = 25;
    localparam int          IGN_MS_3       = 100;
    localparam int          IGN_MS_4       = 500;
    localparam int          IGN_MS_5       = 1000;
    localparam int          IGN_MS_6       = 5000;
    localparam int          IGN_MS_7       = 30000;
    localparam int          IGN_MS_8       = 60000;
    localparam int          IGN_MS_9       = 300000;
    localparam int          MS_CYCLES      = CLK_HZ / 1000;
    localparam logic [13:0] MS_CYCLES_W    = 14'(MS_CYCLES - 1);
    typedef enum logic [2:0] {
        ST_IDLE, ST_P2, ST_P3, ST_CMD, ST_CTRL
    } ssc_state_type;
endpackage : ssc_pkg

// file: hw/ssc_parser.sv
// command parser and traffic steering for a four-port serial switch
`timescale 1ns/10ps
// What this block does
// - sequence is two or three prefixes, command, and control byte for S, X, T.
// - hold candidate bytes; recognized sequences never reach any slave.
// - A-D select slave both ways and flush its buffer; EOT deselects all.
// - send-only routes master data to flagged slaves; talking slave unchanged.
// - control bits 0..3 map to ports A..D, any combination allowed.
// - upper four control bits are ignored for S and X; for T the whole byte is checked.
// - clear-buffer purges receive buffers of flagged slaves.
// - ignore command forwards all master data without detection until timeout.
// - ignore control byte is an ASCII digit 48..57.
// - digit durations 0 off, 10ms,25ms,100ms,500ms,1s,5s,30s,1min,5min.
// - after interval expires, command scanning resumes.
// - DTR-ignore enabled and DTR low passes everything; detection resumes on DTR high.
// - slave-to-master data is never interpreted as commands.
// - auto-select forwards each slave's buffered data to master in turn.
// - host select overrides auto switching; send-only does not stop it.
// - deselect-all during override resumes auto at previous or next ready slave.
module ssc_parser
    import ssc_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    input  wire logic [7:0] i_prefix_byte_first,
    input  wire logic [7:0] i_prefix_byte_second,
    input  wire logic [7:0] i_prefix_byte_optional_third,
    input  wire logic       i_four_char_mode,
    input  wire logic       i_dtr_ignore_en,
    input  wire logic       i_master_dtr,
    input  wire logic       i_auto_select_en,
    input  wire logic [7:0] i_master_data,
    input  wire logic       i_master_valid,
    input  wire logic [3:0] i_slave_has_data,
    input  wire logic       i_slave_packet_done,
    output logic      [7:0] o_slave_data,
    output logic            o_slave_valid,
    output logic      [3:0] o_tx_port_mask,
    output logic      [1:0] o_rx_port,
    output logic            o_rx_enable,
    output logic            o_flush_to_master,
    output logic      [3:0] o_clear_buffer,
    output logic            o_ignore_active
);
    // ===========================================================
    // parser state
    ssc_state_type state;
    logic [7:0]    held [3];
    logic [1:0]    held_cnt;
    logic [7:0]    cmd_byte;
    logic          bypass;
    logic          dtr_bypass;
    logic          ign_on;
    logic [18:0]   ms_left;
    logic [13:0]   ms_div;
    logic          override;
    logic [1:0]    prev_rx;
    logic          prev_valid;
    logic          last_prefix;
    logic [7:0]    second_or_third;
    logic          cmd_known;
    logic          needs_ctrl;
    logic          ctrl_ok;
    logic [18:0]   next_ms_left;
    logic          flush_pend;
    logic [1:0]    flush_slot;
    logic [2:0]    flush_idx;
    logic          clear_req;
    logic [3:0]    clear_mask;
    logic          ign_req;
    logic [18:0]   ign_val;
    logic          sel_req;
    logic [1:0]    sel_port;
    logic          off_req;
    logic          tx_req;
    logic [3:0]    tx_mask;

    assign dtr_bypass      = i_dtr_ignore_en && !i_master_dtr;
    assign bypass          = ign_on || dtr_bypass;
    assign o_ignore_active = bypass;
    assign cmd_known = (i_master_data == CMD_SEL_A) || (i_master_data == CMD_SEL_B) ||
                       (i_master_data == CMD_SEL_C) || (i_master_data == CMD_SEL_D) ||
                       (i_master_data == CMD_OFF) || needs_ctrl;
    assign needs_ctrl = (i_master_data == CMD_SEND_ONLY) || (i_master_data == CMD_CLEAR) ||
                        (i_master_data == CMD_IGNORE);
    assign ctrl_ok    = (cmd_byte != CMD_IGNORE) ||
                        (i_master_data >= DIGIT_ZERO && i_master_data <= DIGIT_NINE);
    assign second_or_third = i_four_char_mode ? i_prefix_byte_optional_third : i_prefix_byte_second;
    assign last_prefix     = i_four_char_mode;

    // digit to milliseconds; zero disables the timer
    always_comb begin
        case (i_master_data[3:0])
            4'h1:    ign_val = 19'(IGN_MS_1);
            4'h2:    ign_val = 19'(IGN_MS_2);
            4'h3:    ign_val = 19'(IGN_MS_3);
            4'h4:    ign_val = 19'(IGN_MS_4);
            4'h5:    ign_val = 19'(IGN_MS_5);
            4'h6:    ign_val = 19'(IGN_MS_6);
            4'h7:    ign_val = 19'(IGN_MS_7);
            4'h8:    ign_val = 19'(IGN_MS_8);
            4'h9:    ign_val = 19'(IGN_MS_9);
            default: ign_val = 19'h00000;
        endcase
    end

    // ===========================================================
    // byte-level decode; only master data is ever scanned
    always_comb begin
        sel_req    = 1'b0;
        sel_port   = i_master_data[1:0] - 2'h1;
        off_req    = 1'b0;
        tx_req     = 1'b0;
        tx_mask    = i_master_data[3:0];
        clear_req  = 1'b0;
        clear_mask = i_master_data[3:0];
        ign_req    = 1'b0;
        if (i_master_valid && !bypass && state == ST_CMD && cmd_known && !needs_ctrl) begin
            sel_req = (i_master_data != CMD_OFF);
            off_req = (i_master_data == CMD_OFF);
        end else if (i_master_valid && !bypass && state == ST_CTRL && ctrl_ok) begin
            tx_req    = (cmd_byte == CMD_SEND_ONLY);
            clear_req = (cmd_byte == CMD_CLEAR);
            ign_req   = (cmd_byte == CMD_IGNORE);
        end
    end

    // ===========================================================
    // sequence tracker; held bytes are never replayed, a mismatch drops them
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state    <= ST_IDLE;
            held_cnt <= 2'h0;
            cmd_byte <= 8'h00;
            held[0]  <= 8'h00;
            held[1]  <= 8'h00;
            held[2]  <= 8'h00;
        end else if (i_master_valid && !bypass) begin
            case (state)
                ST_IDLE: begin
                    if (i_master_data == i_prefix_byte_first) begin
                        state    <= ST_P2;
                        held[0]  <= i_master_data;
                        held_cnt <= 2'h1;
                    end
                end
                ST_P2: begin
                    if (i_master_data == i_prefix_byte_second) begin
                        state    <= last_prefix ? ST_P3 : ST_CMD;
                        held[1]  <= i_master_data;
                        held_cnt <= 2'h2;
                    end else begin
                        state    <= ST_IDLE;
                        held_cnt <= 2'h0;
                    end
                end
                ST_P3: begin
                    if (i_master_data == second_or_third) begin
                        state    <= ST_CMD;
                        held[2]  <= i_master_data;
                        held_cnt <= 2'h3;
                    end else begin
                        state    <= ST_IDLE;
                        held_cnt <= 2'h0;
                    end
                end
                ST_CMD: begin
                    cmd_byte <= i_master_data;
                    state    <= (cmd_known && needs_ctrl) ? ST_CTRL : ST_IDLE;
                    held_cnt <= (cmd_known && needs_ctrl) ? held_cnt : 2'h0;
                end
                default: begin
                    state    <= ST_IDLE;
                    held_cnt <= 2'h0;
                end
            endcase
        end else if (bypass) begin
            state    <= ST_IDLE;
            held_cnt <= 2'h0;
        end
    end

    // ===========================================================
    // forward data to slaves; mismatch drops held prefix bytes
    // (trade-off: no replay buffer, keeps the path one byte wide)
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_slave_data  <= 8'h00;
            o_slave_valid <= 1'b0;
        end else begin
            o_slave_data  <= i_master_data;
            o_slave_valid <= i_master_valid && (o_tx_port_mask != 4'h0) &&
                             (bypass || (state == ST_IDLE && i_master_data != i_prefix_byte_first));
        end
    end

    // ===========================================================
    // ignore timer, millisecond tick from a divider
    assign next_ms_left = (ms_left != 19'h00000) ? ms_left - 19'h00001 : 19'h00000;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ms_left <= 19'h00000;
            ms_div  <= 14'h0000;
            ign_on  <= 1'b0;
        end else if (ign_req) begin
            ms_left <= ign_val;
            ms_div  <= MS_CYCLES_W;
            ign_on  <= (ign_val != 19'h00000);
        end else if (ign_on) begin
            if (ms_div == 14'h0000) begin
                ms_div  <= MS_CYCLES_W;
                ms_left <= next_ms_left;
                ign_on  <= (next_ms_left != 19'h00000);
            end else begin
                ms_div <= ms_div - 14'h0001;
            end
        end
    end

    // ===========================================================
    // steering: transmit mask and receive port
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_tx_port_mask <= PORT_MASK_RST;
        end else if (sel_req) begin
            o_tx_port_mask <= 4'h1 << sel_port;
        end else if (off_req) begin
            o_tx_port_mask <= 4'h0;
        end else if (tx_req) begin
            o_tx_port_mask <= tx_mask;
        end
    end

    // receive side; send-only leaves it alone
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rx_port   <= RX_PORT_RST;
            o_rx_enable <= 1'b0;
            override    <= 1'b0;
            prev_rx     <= RX_PORT_RST;
            prev_valid  <= 1'b0;
        end else if (sel_req) begin
            if (!override) begin
                prev_rx    <= o_rx_port;
                prev_valid <= o_rx_enable;
            end
            o_rx_port   <= sel_port;
            o_rx_enable <= 1'b1;
            override    <= i_auto_select_en;
        end else if (off_req) begin
            override <= 1'b0;
            if (i_auto_select_en && override && prev_valid && i_slave_has_data[prev_rx]) begin
                o_rx_port   <= prev_rx;
                o_rx_enable <= 1'b1;
            end else begin
                o_rx_enable <= 1'b0;
            end
        end else if (i_auto_select_en && !override) begin
            // rotate to next slave with buffered data
            if (!o_rx_enable || i_slave_packet_done || !i_slave_has_data[o_rx_port]) begin
                o_rx_enable <= 1'b0;
                // walk downward so the nearest candidate is assigned last and wins;
                // from idle the search starts at the current port itself
                for (int k = NUM_PORTS - 1; k >= 0; k--) begin
                    if (i_slave_has_data[2'(o_rx_port + 2'(k) + 2'(o_rx_enable))] &&
                        !(o_rx_enable && k == NUM_PORTS - 1)) begin
                        o_rx_port   <= 2'(o_rx_port + 2'(k) + 2'(o_rx_enable));
                        o_rx_enable <= 1'b1;
                    end
                end
            end
        end
    end

    // ===========================================================
    // one-cycle flush and clear strobes
    assign flush_pend = sel_req;
    assign flush_slot = sel_port;
    assign flush_idx  = {1'b0, flush_slot};
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_flush_to_master <= 1'b0;
            o_clear_buffer    <= 4'h0;
        end else begin
            o_flush_to_master <= flush_pend && (flush_idx < 3'(NUM_PORTS));
            o_clear_buffer    <= clear_req ? clear_mask : 4'h0;
        end
    end
endmodule : ssc_parser

// file: verif/ssc_host_model.sv
// host model: drives bytes and dtr on the master serial side
`timescale 1ns/10ps
module ssc_host_model (
    output logic [7:0] o_data,
    output logic       o_valid,
    output logic       o_dtr,
    input  wire logic  i_clk_sys
);
    // ==========
    // idle levels
    initial begin
        o_data  = 8'hA5;
        o_valid = 1'b0;
        o_dtr   = 1'b1;
    end
    // time of the last release; a call in that same step first lets one edge pass
    time t_rel = 0;
    // whole sequences, bytes back to back; caller enters just after an edge
    task automatic send(input logic [7:0] q[$]);
        if (t_rel == $time) begin
            @(posedge i_clk_sys);
            #1;
        end
        foreach (q[i]) begin
            o_data  = q[i];
            o_valid = 1'b1;
            @(posedge i_clk_sys);
            #1;
        end
        o_valid = 1'b0;
        o_data  = ~q[q.size()-1]; // released line must not repeat the byte
        t_rel   = $time;
    endtask : send
    // dtr moves only between sequences, never inside one
    task automatic set_dtr(input logic v);
        o_dtr = v;
    endtask : set_dtr
endmodule : ssc_host_model

// file: verif/ssc_parser_monitor.sv
// checker: port properties of the command parser
`timescale 1ns/10ps
module ssc_parser_monitor
    import ssc_pkg::*;
(
    input wire logic       i_clk_sys,
    input wire logic       i_sys_rst,
    input wire logic [7:0] i_prefix_byte_first,
    input wire logic       i_dtr_ignore_en,
    input wire logic       i_master_dtr,
    input wire logic       i_auto_select_en,
    input wire logic [7:0] i_master_data,
    input wire logic       i_master_valid,
    input wire logic [7:0] o_slave_data,
    input wire logic       o_slave_valid,
    input wire logic [3:0] o_tx_port_mask,
    input wire logic [1:0] o_rx_port,
    input wire logic       o_rx_enable,
    input wire logic       o_flush_to_master,
    input wire logic [3:0] o_clear_buffer,
    input wire logic       o_ignore_active
);
    // ==========
    // length of the running ignore stretch; small margin for edge slack
    localparam int IGN_MIN = 99_990;
    logic [31:0] ign_run;
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ign_run <= 32'h0;
        end else begin
            ign_run <= o_ignore_active ? ign_run + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // ==========
    // properties
    chk_prefix_held: assert property (
        i_master_valid && i_master_data == i_prefix_byte_first && !o_ignore_active |=> !o_slave_valid)
        else $error("prefix byte reached the slaves");
    chk_fwd_copy: assert property (
        o_slave_valid |-> $past(i_master_valid) && o_slave_data == $past(i_master_data) && o_tx_port_mask != 4'h0)
        else $error("forwarded byte not a copy or no port chosen");
    chk_select_both: assert property (
        o_flush_to_master |-> o_rx_enable && o_tx_port_mask == (4'h1 << o_rx_port))
        else $error("select did not join both directions");
    chk_flush_cause: assert property (
        o_flush_to_master |-> $past(i_master_valid) && $past(i_master_data) inside {[CMD_SEL_A:CMD_SEL_D]})
        else $error("flush without a select byte");
    chk_clear_pulse: assert property (
        o_clear_buffer != 4'h0 |-> $past(i_master_valid) ##1 o_clear_buffer == 4'h0)
        else $error("clear strobe not a single cycle after a byte");
    chk_steer_cause: assert property (
        !i_auto_select_en && !$past(i_master_valid) |-> $stable(o_tx_port_mask) && $stable(o_rx_port))
        else $error("steering moved without a master byte");
    chk_dtr_bypass: assert property (
        i_dtr_ignore_en && !i_master_dtr |-> o_ignore_active)
        else $error("dtr low did not bypass detection");
    chk_ignore_pass: assert property (
        o_ignore_active && i_master_valid && o_tx_port_mask != 4'h0 |=> o_slave_valid)
        else $error("byte held while ignoring commands");
    chk_ignore_length: assert property (
        $fell(o_ignore_active) && !$past(i_dtr_ignore_en) |-> ign_run >= IGN_MIN)
        else $error("ignore interval ended early");
endmodule : ssc_parser_monitor
bind ssc_parser ssc_parser_monitor u_mon (.*);

// file: verif/ssc_parser_test.sv
// testbench: command parser driven through the host model
`timescale 1ns/10ps
module ssc_parser_test;
    import ssc_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, four = 1'b0, dtr_en = 1'b0, auto_en = 1'b0, pkt_done = 1'b0;
    logic       dtr, mv, sv, rx_en, flush, ign;
    logic [7:0] md, sd;
    logic [7:0] pfx1 = 8'h1B, pfx2 = 8'h02, pfx3 = 8'h7E;
    logic [3:0] has_data = 4'h0, mask, clr;
    logic [1:0] rx_port;
    int         n_errors = 0, check_count = 0, fwd = 0, cyc = 0, f0;
    ssc_host_model host (.o_data(md), .o_valid(mv), .o_dtr(dtr), .i_clk_sys(clk));
    ssc_parser dut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_prefix_byte_first(pfx1), .i_prefix_byte_second(pfx2),
        .i_prefix_byte_optional_third(pfx3), .i_four_char_mode(four), .i_dtr_ignore_en(dtr_en),
        .i_master_dtr(dtr), .i_auto_select_en(auto_en), .i_master_data(md), .i_master_valid(mv),
        .i_slave_has_data(has_data), .i_slave_packet_done(pkt_done), .o_slave_data(sd), .o_slave_valid(sv),
        .o_tx_port_mask(mask), .o_rx_port(rx_port), .o_rx_enable(rx_en), .o_flush_to_master(flush),
        .o_clear_buffer(clr), .o_ignore_active(ign));
    // ==========
    // clock, forwarded-byte count and hang guard (the long ignore wait is ~100k cycles)
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        if (sv === 1'b1) fwd <= fwd + 1;
        cyc <= cyc + 1;
        if (cyc == 130000) begin
            n_errors++;
            wrap_up();
        end
    end
    // ==========
    // helpers
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_val({7'h0, got}, {7'h0, exp});
    endtask : cmp_bit
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic do_reset();
        rst = 1'b1;
        tick(6);
        rst = 1'b0;
    endtask : do_reset
    // prefixes, command, optional control byte
    task automatic cmd(input logic [7:0] c, input int ctl = -1);
        logic [7:0] q[$];
        q = '{pfx1, pfx2};
        if (four) q.push_back(pfx3);
        q.push_back(c);
        if (ctl >= 0) q.push_back(ctl[7:0]);
        host.send(q);
    endtask : cmd
    task automatic wait_rx(input logic [1:0] p);
        for (int k = 0; k < 20 && !(rx_en === 1'b1 && rx_port === p); k++) tick(1);
        cmp_val({6'h0, rx_port}, {6'h0, p});
        cmp_bit(rx_en, 1'b1);
    endtask : wait_rx
    task automatic wrap_up();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    // ==========
    // main sequence
    initial begin
        do_reset();
        for (int i = 0; i < 4; i++) begin
            f0 = fwd;
            cmd(8'(CMD_SEL_A + i));
            cmp_bit(flush, 1'b1);
            cmp_val({4'h0, mask}, 8'(1 << i));
            cmp_val({6'h0, rx_port}, 8'(i));
            tick(1); // lets a forward of the command byte be counted
            cmp_val(8'(fwd - f0), 8'h0);
        end
        host.send('{8'h5A});
        cmp_bit(sv, 1'b1);
        cmp_val(sd, 8'h5A);
        cmd(CMD_OFF);
        cmp_val({3'h0, rx_en, mask}, 8'h0);
        cmd(CMD_SEL_C);
        for (int m = 0; m < 16; m++) begin
            cmd(CMD_SEND_ONLY, m + (m[0] ? 64 : 0)); // upper bits set on odd codes
            cmp_val({4'h0, mask}, 8'(m));
            cmp_val({6'h0, rx_port}, 8'h2);
            cmd(CMD_CLEAR, m + (m[1] ? 64 : 0));
            cmp_val({4'h0, clr}, 8'(m));
        end
        four = 1'b1;
        cmd(CMD_SEL_B);
        cmp_val({4'h0, mask}, 8'h2);
        four = 1'b0;
        // prefix is programmable: a new first prefix opens sequences, the old one is plain data
        pfx1 = 8'h21;
        cmd(CMD_SEL_C);
        cmp_val({4'h0, mask}, 8'h4);
        host.send('{8'h1B});
        cmp_bit(sv, 1'b1);
        pfx1 = 8'h1B;
        cmd(CMD_IGNORE, 8'h3A);
        cmd(CMD_IGNORE, 8'h30);
        tick(1);
        cmp_bit(ign, 1'b0);
        cmd(CMD_SEL_A);
        cmd(CMD_IGNORE, 8'h31);
        cmp_bit(ign, 1'b1);
        f0 = fwd;
        cmd(CMD_SEL_B);
        tick(1);
        cmp_val(8'(fwd - f0), 8'h3);
        cmp_val({4'h0, mask}, 8'h1);
        tick(99_980);
        cmp_bit(ign, 1'b1);
        tick(30);
        cmp_bit(ign, 1'b0);
        cmd(CMD_SEL_B);
        cmp_val({4'h0, mask}, 8'h2);
        for (int d = 2; d < 10; d++) begin
            do_reset();
            cmd(CMD_IGNORE, 48 + d);
            tick(50);
            cmp_bit(ign, 1'b1);
        end
        do_reset();
        dtr_en = 1'b1;
        cmd(CMD_SEL_B);
        host.set_dtr(1'b0);
        tick(1);
        cmp_bit(ign, 1'b1);
        f0 = fwd;
        cmd(CMD_SEL_D);
        tick(1);
        cmp_val(8'(fwd - f0), 8'h3);
        cmp_val({4'h0, mask}, 8'h2);
        host.set_dtr(1'b1);
        cmd(CMD_SEL_D);
        cmp_val({4'h0, mask}, 8'h8);
        // auto mode is switched on under reset so no stale rotation leaks in
        auto_en = 1'b1;
        do_reset();
        has_data = 4'h5;
        wait_rx(2'h0);
        pkt_done = 1'b1;
        tick(1);
        pkt_done = 1'b0;
        wait_rx(2'h2);
        cmd(CMD_SEND_ONLY, 8'h03);
        cmp_val({6'h0, rx_port}, 8'h2);
        cmd(CMD_SEL_B);
        pkt_done = 1'b1;
        tick(1);
        pkt_done = 1'b0;
        tick(4);
        cmp_val({6'h0, rx_port}, 8'h1);
        cmd(CMD_OFF);
        wait_rx(2'h2);
        // port C drained while A, B and D hold data: the nearest port upward, D, must follow
        has_data = 4'hB;
        wait_rx(2'h3);
        wrap_up();
    end
endmodule : ssc_parser_test
